// ### vic_defines.vh
// constants for the vectored interrupt controller
// Contract
// - accept 64 channels, 16 from external pins
// - per-channel mask blocks both outputs
// - each channel steered to fast or normal
// - exactly two outputs, fast and normal
// - hardware picks winner among simultaneous requests
// - eight priority levels, two fast, six normal
// - software-loadable entry address table per level
// - winner's entry address loaded into entry register
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH
// ****************************************
// sizes
// ****************************************
`define VIC_NCHAN 64
`define VIC_NEXT 16
`define VIC_NPER 48
`define VIC_CHW 6
`define VIC_PRW 3
`define VIC_NLEV 8
`define VIC_ADW 32
// ****************************************
// priority classes: levels 0..1 fast, 2..7 normal
// ****************************************
`define VIC_FAST_LEVELS 2
`define VIC_PRIO_RESET 3'h7
`define VIC_MASK_RESET 64'h0000000000000000
`define VIC_ENTRY_RESET 32'h00000000
`endif

// ### vic_top.v
// vectored interrupt controller with priority ranking and entry table
`timescale 1ns/10ps
`include "vic_defines.vh"
module vic_top (
  input wire mclk,
  input wire rst_b,
  input wire [`VIC_NPER-1:0] periph_req,
  input wire [`VIC_NEXT-1:0] ext_req_pin,
  input wire [`VIC_NCHAN-1:0] chan_enable,
  input wire [`VIC_NCHAN*`VIC_PRW-1:0] chan_prio,
  input wire tbl_wr,
  input wire [`VIC_PRW-1:0] tbl_idx,
  input wire [`VIC_ADW-1:0] tbl_data,
  output reg fast_interrupt_request_q,
  output reg irq_q,
  output reg [`VIC_ADW-1:0] entry_q,
  output reg [`VIC_CHW-1:0] win_chan_q,
  output reg win_valid_q
);
  // ****************************************
  // external pin synchronisers
  // ****************************************
  reg [`VIC_NEXT-1:0] ext_s1_q;
  reg [`VIC_NEXT-1:0] ext_s2_q;
  reg [`VIC_NEXT-1:0] ext_s3_q;
  reg [`VIC_NEXT-1:0] ext_q;
  // three stages; accept change once stages two and three agree
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 16'h0000;
      ext_s2_q <= 16'h0000;
      ext_s3_q <= 16'h0000;
      ext_q <= 16'h0000;
    end else begin
      ext_s1_q <= ext_req_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ext_q <= (ext_s2_q & ext_s3_q) | (ext_q & (ext_s2_q | ext_s3_q));
    end
  end
  // ****************************************
  // request vector and masking
  // ****************************************
  wire [`VIC_NCHAN-1:0] req_all;
  wire [`VIC_NCHAN-1:0] req_live;
  assign req_all = {ext_q, periph_req};
  assign req_live = req_all & chan_enable;
  // ****************************************
  // entry address table
  // ****************************************
  reg [`VIC_ADW-1:0] tbl_q [0:`VIC_NLEV-1];
  integer ti;
  // software loads one entry per priority level
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (ti = 0; ti < `VIC_NLEV; ti = ti + 1) begin
        tbl_q[ti] <= `VIC_ENTRY_RESET;
      end
    end else if (tbl_wr) begin
      tbl_q[tbl_idx] <= tbl_data;
    end
  end
  // ****************************************
  // priority ranking
  // ****************************************
  wire [`VIC_NCHAN-1:0] fast_hit;
  wire [`VIC_NCHAN-1:0] norm_hit;
  wire [`VIC_NLEV-1:0] lev_any;
  genvar g;
  generate
    for (g = 0; g < `VIC_NCHAN; g = g + 1) begin : g_chan
      wire [`VIC_PRW-1:0] p;
      assign p = chan_prio[g*`VIC_PRW +: `VIC_PRW];
      // levels below two go fast, others normal
      assign fast_hit[g] = req_live[g] & (p < `VIC_FAST_LEVELS);
      assign norm_hit[g] = req_live[g] & (p >= `VIC_FAST_LEVELS);
    end
    for (g = 0; g < `VIC_NLEV; g = g + 1) begin : g_lev
      wire [`VIC_NCHAN-1:0] m;
      genvar c;
      for (c = 0; c < `VIC_NCHAN; c = c + 1) begin : g_m
        assign m[c] = req_live[c] &
          (chan_prio[c*`VIC_PRW +: `VIC_PRW] == g);
      end
      assign lev_any[g] = |m;
    end
  endgenerate
  // pick best level, then lowest channel inside it
  reg [`VIC_PRW-1:0] best_lev;
  reg [`VIC_CHW-1:0] best_ch;
  reg best_ok;
  integer i;
  always @* begin
    best_lev = 3'h0;
    best_ch = 6'h00;
    best_ok = 1'b0;
    for (i = `VIC_NLEV - 1; i >= 0; i = i - 1) begin
      if (lev_any[i]) begin
        best_lev = i[`VIC_PRW-1:0];
        best_ok = 1'b1;
      end
    end
    for (i = `VIC_NCHAN - 1; i >= 0; i = i - 1) begin
      if (req_live[i] &&
          chan_prio[i*`VIC_PRW +: `VIC_PRW] == best_lev) begin
        best_ch = i[`VIC_CHW-1:0];
      end
    end
  end
  // ****************************************
  // outputs toward the core
  // ****************************************
  // two level outputs and the winner's entry address
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fast_interrupt_request_q <= 1'b0;
      irq_q <= 1'b0;
      entry_q <= `VIC_ENTRY_RESET;
      win_chan_q <= 6'h00;
      win_valid_q <= 1'b0;
    end else begin
      fast_interrupt_request_q <= |fast_hit;
      irq_q <= |norm_hit;
      win_valid_q <= best_ok;
      if (best_ok) begin
        entry_q <= tbl_q[best_lev];
        win_chan_q <= best_ch;
      end
    end
  end
endmodule // vic_top

// ### vic_monitor.sv
// checker of interrupt controller outputs
`timescale 1ns/10ps
module vic_monitor(input wire mclk,rst_b,irq_q,win_valid_q,
 input wire fast_interrupt_request_q,input wire [47:0] periph_req,
 input wire [63:0] chan_enable,input wire [191:0] chan_prio,
 input wire [5:0] win_chan_q);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_b);
wire f=fast_interrupt_request_q;
reg [191:0] pp;
reg [63:0] pe;
reg [47:0] pq;
// inputs one cycle back
always @(posedge mclk) {pp,pe,pq}<={chan_prio,chan_enable,periph_req};
a_mask_quiet: assert property (chan_enable==0 |=> !f&&!irq_q)
 else $error("out while masked");
a_valid_follow: assert property (|(periph_req&chan_enable[47:0])
 |=> win_valid_q) else $error("no winner");
a_one_out: assert property (win_valid_q |-> f||irq_q)
 else $error("no output");
a_out_valid: assert property (f||irq_q |-> win_valid_q)
 else $error("stray output");
a_win_enabled: assert property (win_valid_q |-> pe[win_chan_q])
 else $error("masked winner");
a_win_request: assert property (win_valid_q&&win_chan_q<48
 |-> pq[win_chan_q]) else $error("idle winner");
a_fast_level: assert property (f |-> pp[3*win_chan_q+:3]<2)
 else $error("fast class");
a_win_hold: assert property (!win_valid_q&&$past(win_valid_q)
 |-> $stable(win_chan_q)) else $error("winner lost");
cover property (f);
cover property (irq_q&&!f);
cover property (win_valid_q&&win_chan_q>47);
endmodule // vic_monitor
bind vic_top vic_monitor u_vic_monitor(.*);

// ### vic_core.sv
// core model taking interrupt lines
`timescale 1ns/10ps
module vic_core(input wire mclk,fq,iq,input wire [31:0] ent,
 output reg [31:0] taken);
  // fetch handler address on any raised line
  always @(posedge mclk) if (fq|iq) taken<=ent;
endmodule // vic_core

// ### tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
module tb_top;
reg mclk=0,rst_b=0,tbl_wr=0;
reg [2:0] tbl_idx=0;
reg [31:0] tbl_data=0,he=0,tb[0:7];
reg [63:0] rq=0,en=0;
reg [191:0] pr=0;
reg [5:0] hc=0;
reg [40:0] q[$],e;
wire fq,iq,wv;
wire [31:0] ent;
wire [5:0] wc;
integer seed=31431,err_total=0,checks=0,cyc=0,i,k;
event look;
initial forever #4 mclk=~mclk;
vic_top u_vic_top(.mclk(mclk),.rst_b(rst_b),.periph_req(rq[47:0]),
 .ext_req_pin(rq[63:48]),.chan_enable(en),.chan_prio(pr),.tbl_wr(tbl_wr),
 .tbl_idx(tbl_idx),.tbl_data(tbl_data),.fast_interrupt_request_q(fq),
 .irq_q(iq),.entry_q(ent),.win_chan_q(wc),.win_valid_q(wv));
vic_core u_vic_core(.mclk(mclk),.fq(fq),.iq(iq),.ent(ent),.taken());
task chk(input [39:0] n,input [31:0] s,t);
  begin
    checks=checks+1;
    if (s!==t) begin
      err_total=err_total+1;
      $display("BAD %0s exp %h got %h",n,t,s);
    end
  end
endtask
task summarize;
  begin
    $display("checks %0d errors %0d",checks,err_total);
    if (err_total==0&&checks>0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end
endtask
// note expected winner, then let outputs settle
task drive;
  integer c,f,n,b,lv;
  begin
    f=0; n=0; b=64; lv=8;
    for (c=0;c<64;c=c+1) if (rq[c]&en[c]) begin
      if (pr[3*c+:3]<2) f=1; else n=1;
      if (pr[3*c+:3]<lv) begin lv=pr[3*c+:3]; b=c; end
    end
    if (b<64) begin hc=b; he=tb[lv]; end
    q.push_back({f[0],n[0],b<64,hc,he});
    repeat (5) @(negedge mclk);
    ->look;
  end
endtask
// compare outputs with oldest note
always @(look) begin
  e=q.pop_front();
  chk("fast",fq,e[40]);
  chk("irq",iq,e[39]);
  chk("valid",wv,e[38]);
  chk("chan",wc,e[37:32]);
  chk("entry",ent,e[31:0]);
end
always @(posedge mclk) begin
  cyc=cyc+1;
  if (cyc==2000) begin err_total=err_total+1; summarize; end
end
initial begin
  repeat (20) @(negedge mclk);
  rst_b=1;
  for (k=0;k<8;k=k+1) begin
    tb[k]=$random(seed); tbl_idx=k; tbl_data=tb[k]; tbl_wr=1;
    @(negedge mclk);
  end
  tbl_wr=0;
  for (i=0;i<40;i=i+1) begin
    rq={$random(seed),$random(seed)};
    en=(i%4)?{$random(seed),$random(seed)}:64'h0;
    for (k=0;k<64;k=k+1) pr[3*k+:3]=(i%5)?$random(seed):4;
    drive;
  end
  summarize;
end
endmodule // tb_top
